// >>> core/itd_regs.sv
// file: image transfer and drawing setup register bank
`timescale 1ns/10ps
// Functional notes
// - line count register holds 11 bits
// - byte or word writes accepted
// - writing start bit launches transfer
// - start bit resets zero, self-clears
// - completion gives ~1us low pulse
// - start X holds 11 bits, reset zero
// - start Y holds 10 bits, reset zero
// - end X holds 11 bits, reset zero
// - end Y holds 10 bits, reset zero
// - coordinates shared by fill and line
// - image width register outside this bank
// - source address register outside this bank
module itd_regs (
  input  wire logic                        sys_clk_in,
  input  wire logic                        reset_in,
  input  wire logic [itd_pkg::ADDR_W-1:0]  bus_addr_in,
  input  wire logic [itd_pkg::DATA_W-1:0]  bus_wdata_in,
  input  wire logic                        bus_wr_in,
  input  wire logic                        bus_word_in,
  input  wire logic                        xfer_done_in,
  output logic [itd_pkg::LINE_W-1:0]       image_line_count_out,
  output logic [itd_pkg::COORDX_W-1:0]     draw_start_x_out,
  output logic [itd_pkg::COORDY_W-1:0]     draw_start_y_out,
  output logic [itd_pkg::COORDX_W-1:0]     draw_end_x_out,
  output logic [itd_pkg::COORDY_W-1:0]     draw_end_y_out,
  output logic [itd_pkg::COLOR_W-1:0]      draw_color_palette_out,
  output logic                             start_trigger_out,
  output logic                             xfer_busy_out,
  output logic                             completion_irq_n_out
);
  import itd_pkg::*;

  // registered state of the bank
  typedef struct packed {
    logic [LINE_W-1:0]    line_count;
    logic [COORDX_W-1:0]  start_x;
    logic [COORDY_W-1:0]  start_y;
    logic [COORDX_W-1:0]  end_x;
    logic [COORDY_W-1:0]  end_y;
    logic [COLOR_W-1:0]   color;
    logic                 start_trigger;
    logic                 busy;
    itd_state_t           state;
    logic [IRQ_CNT_W-1:0] irq_cnt;
    logic                 irq_n;
  } itd_state_s_t;

  itd_state_s_t r;
  itd_state_s_t next_r;

  // byte lane decode
  logic [ADDR_W-1:0] even_addr;
  logic              is_odd;
  logic              hi_we;
  logic              lo_we;
  logic [7:0]        hi_byte;
  logic [7:0]        lo_byte;

  // shared register selects
  logic              sel_ctrl;
  logic              sel_color;
  logic              start_req;

  always_comb begin
    next_r    = r;

    is_odd    = bus_addr_in[0];
    even_addr = {bus_addr_in[ADDR_W-1:1], 1'b0};
    hi_we     = bus_wr_in && (bus_word_in || !is_odd);
    lo_we     = bus_wr_in && (bus_word_in || is_odd);
    hi_byte   = bus_word_in ? bus_wdata_in[15:8] : bus_wdata_in[7:0];
    lo_byte   = bus_wdata_in[7:0];

    // control and colour decode
    sel_ctrl  = (even_addr == ADDR_XFER_CTRL);
    sel_color = (even_addr == {ADDR_COLOR[ADDR_W-1:1], 1'b0});
    start_req = hi_we && sel_ctrl && hi_byte[START_BIT];

    unique case (even_addr)
      ADDR_LINE_COUNT: begin
        if (hi_we) begin
          next_r.line_count[LINE_W-1:8] = hi_byte[LINE_W-9:0];
        end
        if (lo_we) begin
          next_r.line_count[7:0] = lo_byte;
        end
      end

      ADDR_START_X: begin
        if (hi_we) begin
          next_r.start_x[COORDX_W-1:8] = hi_byte[COORDX_W-9:0];
        end
        if (lo_we) begin
          next_r.start_x[7:0] = lo_byte;
        end
      end

      ADDR_START_Y: begin
        if (hi_we) begin
          next_r.start_y[COORDY_W-1:8] = hi_byte[COORDY_W-9:0];
        end
        if (lo_we) begin
          next_r.start_y[7:0] = lo_byte;
        end
      end

      ADDR_END_X: begin
        if (hi_we) begin
          next_r.end_x[COORDX_W-1:8] = hi_byte[COORDX_W-9:0];
        end
        if (lo_we) begin
          next_r.end_x[7:0] = lo_byte;
        end
      end

      ADDR_END_Y: begin
        if (hi_we) begin
          next_r.end_y[COORDY_W-1:8] = hi_byte[COORDY_W-9:0];
        end
        if (lo_we) begin
          next_r.end_y[7:0] = lo_byte;
        end
      end

      default: begin
        // control and colour decoded below
        // width register kept elsewhere
      end
    endcase

    // colour sits on the odd byte of its word
    if (lo_we && sel_color) begin
      next_r.color = lo_byte;
    end

    next_r.start_trigger = 1'b0;
    unique case (r.state)
      ITD_IDLE: begin
        if (start_req) begin
          next_r.start_trigger = 1'b1;
          next_r.busy          = 1'b1;
          next_r.state         = ITD_BUSY;
        end
      end

      ITD_BUSY: begin
        // transfer running, starts ignored
        if (xfer_done_in) begin
          next_r.state   = ITD_PULSE;
          next_r.irq_n   = 1'b0;
          next_r.irq_cnt = '0;
        end
      end

      ITD_PULSE: begin
        // low pulse of about 1 us
        if (r.irq_cnt == IRQ_LAST) begin
          next_r.irq_n = 1'b1;
          next_r.busy  = 1'b0;
          next_r.state = ITD_IDLE;
        end else begin
          // count out the pulse width
          next_r.irq_cnt = r.irq_cnt + 8'h01;
        end
      end

      default: begin
        // unused state code falls back to idle
        next_r.busy  = 1'b0;
        next_r.irq_n = 1'b1;
        next_r.state = ITD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      r.line_count    <= RST_LINE;
      r.start_x       <= RST_X;
      r.start_y       <= RST_Y;
      r.end_x         <= RST_X;
      r.end_y         <= RST_Y;
      r.color         <= RST_COLOR;
      r.start_trigger <= 1'b0;
      r.busy          <= 1'b0;
      r.state         <= ITD_IDLE;
      r.irq_cnt       <= '0;
      r.irq_n         <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign image_line_count_out   = r.line_count;
  assign draw_start_x_out       = r.start_x;
  assign draw_start_y_out       = r.start_y;
  assign draw_end_x_out         = r.end_x;
  assign draw_end_y_out         = r.end_y;
  assign draw_color_palette_out = r.color;
  assign start_trigger_out      = r.start_trigger;
  assign xfer_busy_out          = r.busy;
  assign completion_irq_n_out   = r.irq_n;
endmodule : itd_regs

// >>> pkg/itd_pkg.sv
// package: register map, field widths and timing for the image/draw setup registers
package itd_pkg;
  // byte bus widths
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  // register byte addresses (even address carries the high byte)
  localparam logic [22:0] ADDR_LINE_COUNT = 23'h7f_ffcc;
  localparam logic [22:0] ADDR_XFER_CTRL  = 23'h7f_ffce;
  localparam logic [22:0] ADDR_START_X    = 23'h7f_ffd0;
  localparam logic [22:0] ADDR_START_Y    = 23'h7f_ffd2;
  localparam logic [22:0] ADDR_END_X      = 23'h7f_ffd4;
  localparam logic [22:0] ADDR_END_Y      = 23'h7f_ffd6;
  localparam logic [22:0] ADDR_COLOR      = 23'h7f_ffd9;
  // field widths
  localparam int LINE_W  = 11;
  localparam int COORDX_W = 11;
  localparam int COORDY_W = 10;
  localparam int COLOR_W = 8;
  localparam int START_BIT = 0;
  // reset values
  localparam logic [10:0] RST_LINE  = 11'h000;
  localparam logic [10:0] RST_X     = 11'h000;
  localparam logic [9:0]  RST_Y     = 10'h000;
  localparam logic [7:0]  RST_COLOR = 8'h00;
  // completion pulse width: about 1 us at 250 MHz
  localparam int CLK_PERIOD_PS = 4000;
  localparam int IRQ_PULSE_NS  = 1000;
  localparam int IRQ_CYCLES    = (IRQ_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int IRQ_CNT_W     = 8;
  localparam logic [7:0] IRQ_LAST = 8'(IRQ_CYCLES - 1);
  typedef enum logic [1:0] { ITD_IDLE, ITD_BUSY, ITD_PULSE } itd_state_t;
endpackage : itd_pkg

// >>> verification/itd_engine.sv
// partner: transfer engine answering each start with a one-cycle done
`timescale 1ns/10ps
module itd_engine (
  input  wire logic       sys_clk_in,
  input  wire logic       start_in,
  input  wire logic [9:0] lat_in,
  output logic            done_out
);
  int cnt = 0;
  initial done_out = 1'h0;
  // done pulse after the set latency
  always @(posedge sys_clk_in) begin
    done_out <= (cnt == 1);
    cnt <= start_in ? int'(lat_in) : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule : itd_engine

// >>> verification/itd_regs_chk.sv
// checker: trigger, completion pulse and write lane assertions
`timescale 1ns/10ps
module itd_regs_chk (
  input wire logic        sys_clk_in,
  input wire logic        reset_in,
  input wire logic [22:0] bus_addr_in,
  input wire logic [15:0] bus_wdata_in,
  input wire logic        bus_wr_in,
  input wire logic        bus_word_in,
  input wire logic        xfer_done_in,
  input wire logic [10:0] image_line_count_out,
  input wire logic [10:0] draw_start_x_out,
  input wire logic [9:0]  draw_start_y_out,
  input wire logic [10:0] draw_end_x_out,
  input wire logic [9:0]  draw_end_y_out,
  input wire logic [7:0]  draw_color_palette_out,
  input wire logic        start_trigger_out,
  input wire logic        xfer_busy_out,
  input wire logic        completion_irq_n_out
);
  import itd_pkg::*;
  logic [8:0] low_cnt;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // cycles spent with the completion output low
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      low_cnt <= 9'h000;
    end else begin
      low_cnt <= completion_irq_n_out ? 9'h000 : low_cnt + 9'h001;
    end
  end
  sequence bw(logic [22:0] a, logic w);
    bus_wr_in && bus_word_in == w && bus_addr_in == a;
  endsequence
  trig_launch_a: assert property (
    bw(ADDR_XFER_CTRL, 1'h0) ##0 bus_wdata_in[0] && !xfer_busy_out |=> start_trigger_out)
    else $error("no trigger");
  trig_word_a: assert property (
    bw(ADDR_XFER_CTRL, 1'h1) ##0 bus_wdata_in[8] && !xfer_busy_out |=> start_trigger_out)
    else $error("no word trigger");
  trig_cause_a: assert property (
    start_trigger_out |-> $past(bus_wr_in) && !$past(xfer_busy_out))
    else $error("stray trigger");
  trig_clear_a: assert property (
    start_trigger_out |=> !start_trigger_out && xfer_busy_out)
    else $error("trigger stuck");
  irq_cause_a: assert property (
    $fell(completion_irq_n_out) |-> $past(xfer_done_in) && xfer_busy_out)
    else $error("stray irq");
  irq_width_a: assert property (
    $rose(completion_irq_n_out) |-> low_cnt == 9'(IRQ_CYCLES) && !xfer_busy_out)
    else $error("irq width");
  line_word_a: assert property (
    bw(ADDR_LINE_COUNT, 1'h1) |=> image_line_count_out == $past(bus_wdata_in[10:0]))
    else $error("line word");
  sx_hi_a: assert property (
    bw(ADDR_START_X, 1'h0) |=> draw_start_x_out ==
    {$past(bus_wdata_in[2:0]), $past(draw_start_x_out[7:0])})
    else $error("x high");
  ey_lo_a: assert property (
    bw(ADDR_END_Y + 23'h1, 1'h0) |=> draw_end_y_out ==
    {$past(draw_end_y_out[9:8]), $past(bus_wdata_in[7:0])})
    else $error("y low");
  color_lo_a: assert property (
    bw(ADDR_COLOR, 1'h0) |=> draw_color_palette_out == $past(bus_wdata_in[7:0]))
    else $error("colour byte");
endmodule : itd_regs_chk
bind itd_regs itd_regs_chk i_itd_regs_chk (.*);

// >>> verification/testbench.sv
// testbench: register writes, start trigger and completion pulse
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("Error %0t got %h exp %h", $time, a, b); end end
module testbench;
  import itd_pkg::*;
  logic clk = 0, rst = 1, wr = 0, word = 0, done, trg, busy, irq_n;
  logic [22:0] addr = 0;
  logic [15:0] wdata = 0;
  logic [9:0] lat = 10'h001, sy, ey;
  logic [10:0] lc, sx, ex;
  logic [7:0] col;
  int fails = 0, checks_done = 0, cyc = 0;
  itd_regs i_itd_regs (.sys_clk_in(clk), .reset_in(rst), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_wr_in(wr), .bus_word_in(word), .xfer_done_in(done), .image_line_count_out(lc),
    .draw_start_x_out(sx), .draw_start_y_out(sy), .draw_end_x_out(ex), .draw_end_y_out(ey),
    .draw_color_palette_out(col), .start_trigger_out(trg), .xfer_busy_out(busy),
    .completion_irq_n_out(irq_n));
  itd_engine i_itd_engine (.sys_clk_in(clk), .start_in(trg), .lat_in(lat), .done_out(done));
  task automatic wr_t(input logic [22:0] a, input logic [15:0] d, input logic w);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    word <= w;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    #1;
  endtask : wr_t
  task automatic t_reset();
    #1;
    `CHK({lc, sx, sy, ex, ey, col, trg, busy, irq_n}, 64'h0000_0000_0000_0001)
  endtask : t_reset
  task automatic t_regs();
    logic [22:0] a[4] = '{ADDR_START_X, ADDR_START_Y, ADDR_END_X, ADDR_END_Y};
    foreach (a[i]) wr_t(a[i], 16'hffff, 1'h1);
    wr_t(ADDR_START_X, 16'h0002, 1'h0);
    wr_t(ADDR_END_Y + 23'h1, 16'h0012, 1'h0);
    wr_t(ADDR_LINE_COUNT, 16'hf923, 1'h1); // bits above the 11-bit field are dropped
    wr_t(ADDR_COLOR, 16'h00c5, 1'h0); // palette colour byte on the odd address
    wr_t(ADDR_COLOR - 23'h1, 16'h00ff, 1'h0);
    wr_t(23'h7f_ffda, 16'h0000, 1'h1);
    `CHK({lc, sx, sy, ex, ey, col}, {11'h123, 11'h2ff, 10'h3ff, 11'h7ff, 10'h312, 8'hc5})
  endtask : t_regs
  task automatic t_start(input logic [9:0] l, input logic w);
    int n = 0;
    lat = l;
    wr_t(ADDR_XFER_CTRL, w ? 16'h0100 : 16'h0001, w);
    `CHK({trg, busy}, 2'h3)
    wr_t(ADDR_XFER_CTRL, w ? 16'h0001 : 16'h0100, !w);
    `CHK(trg, 1'h0)
    while (irq_n === 1'h1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (irq_n === 1'h0 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK({n, busy}, {IRQ_CYCLES, 1'h0})
  endtask : t_start
  task automatic finish_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_regs();
    t_start(10'h12c, 1'h0);
    t_start(10'h001, 1'h1);
    finish_test();
  end
endmodule : testbench
